// File: rtl/isv_source_vectoring.sv
// Behaviour
// - NMI is top priority, ignores all masks, vector 7.
// - NMI requests on rising or falling edge per edge select.
// - Only NMI and pin requests 0..2 wake from software standby.
// - Each pin requests on low level or falling edge per sense bit.
// - A pin request reaches arbitration only while its enable bit is set.
// - Pins 0, 1 have own priority bits; 2-3 share; 4-7 share.
// - Pin pending flags are cleared by software writing 1 to the clear bits.
// - Pins 0..7 take vectors 12..19 ascending.
// - Pins are detected whatever their direction setting.
// - Accept 34 internal requests, priorities from registers A and B.
// - Timer or serial requests routed to DMA never reach the controller.
// - Equal priority level: smaller vector number wins.
// - Reset gives default order; all but NMI reprioritisable.
// - Vector address low 16 bits is four times vector number.
// - Watchdog 20, refresh 21 under A bit 3; 22, 23 reserved.
// - Timers 0..2 at 24, 28, 32 under A bits 2, 1, 0.
// - Timers 3, 4 at 36, 40 under B bits 7, 6.
// - Serial 0, 1 at 52, 56 under B bits 3, 2.
// - Pin flag sets while low (level) or on high-to-low (edge).
// - Priority bit 1 gives level 1, above all level-0 sources.
// - Conversion-end priority comes from B bit 1.
// - Simultaneous equal-level requests: fixed order picks, rest stay pending.
`timescale 1ns/1ps
`default_nettype none
`include "isv_cfg.svh"
module isv_source_vectoring (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Pins
  input wire logic nmi_pin_i,
  input wire logic [7:0] irq_pin_n_i,
  // Control registers, held outside
  input wire logic nmi_edge_select_i,
  input wire logic [7:0] pin_sense_select_reg_i,
  input wire logic [7:0] pin_request_enable_reg_i,
  input wire logic [7:0] priority_reg_a_i,
  input wire logic [7:0] priority_reg_b_i,
  input wire logic [7:0] pin_flag_clear_i,
  // Internal module requests
  input wire logic watchdog_interval_request_i,
  input wire logic refresh_compare_request_i,
  input wire logic [14:0] timer_unit_request_i,
  input wire logic [14:0] timer_dma_route_i,
  input wire logic [7:0] dma_transfer_end_request_i,
  input wire logic [7:0] serial_unit_request_i,
  input wire logic [7:0] serial_dma_route_i,
  input wire logic conversion_end_request_i,
  // Core side
  input wire logic nmi_ack_i,
  output logic [7:0] pin_request_flag_reg_o,
  output logic nmi_pending_o,
  output logic req_valid_o,
  output logic req_level_o,
  output isv_pkg::isv_vec_t req_vector_o,
  output isv_pkg::isv_addr_t req_vec_addr_o,
  output isv_pkg::isv_src_t req_source_o,
  output logic wake_o
);

  // ----------------------------------------------------------------
  // External pins
  // ----------------------------------------------------------------
  logic [7:0] pin_flag;
  logic [7:0] pin_low;
  // Flags are kept even while a pin is disabled so software can still poll
  // them; only the request into arbitration and the pin wake are gated by the enable bits.
  // Direction bits are not inputs here: pins are sensed in any mode.
  for (genvar i = 0; i < `ISV_NUM_PINS; i++) begin : g_pin
    isv_pin_detect u_pin (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .pin_n_i(irq_pin_n_i[i]),
      .sense_edge_i(pin_sense_select_reg_i[i]),
      .clear_i(pin_flag_clear_i[i]),
      .flag_o(pin_flag[i]),
      .asserted_o(pin_low[i])
    );
  end

  // ----------------------------------------------------------------
  // Non-maskable input
  // ----------------------------------------------------------------
  logic nmi_s1_ff;
  logic nmi_s2_ff;
  logic nmi_prev_ff;
  logic nmi_pend_ff;
  logic nxt_nmi_s1;
  logic nxt_nmi_s2;
  logic nxt_nmi_prev;
  logic nxt_nmi_pend;
  logic nmi_edge;

  // The synchroniser resets low whatever the pin's idle level, so its first
  // samples could look like an edge. Edges count only once the chain holds
  // real pin samples, which costs nothing after the first few cycles.
  logic [1:0] nmi_fill_ff;
  logic [1:0] nxt_nmi_fill;
  logic nmi_armed;

  always_comb begin
    nxt_nmi_s1 = nmi_pin_i;
    nxt_nmi_s2 = nmi_s1_ff;
    nxt_nmi_prev = nmi_s2_ff;
    nmi_armed = (nmi_fill_ff == `ISV_SYNC_FILL);
    nxt_nmi_fill = nmi_armed ? nmi_fill_ff : nmi_fill_ff + 2'h1;
    nmi_edge = nmi_armed & (nmi_edge_select_i ? (nmi_s2_ff & ~nmi_prev_ff)
                                              : (~nmi_s2_ff & nmi_prev_ff));
    // A new edge in the acknowledge cycle keeps the request pending.
    // The core must pulse the acknowledge for one cycle per accepted request.
    nxt_nmi_pend = nmi_edge | (nmi_pend_ff & ~nmi_ack_i);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nmi_s1_ff <= 1'b0;
      nmi_s2_ff <= 1'b0;
      nmi_prev_ff <= 1'b0;
      nmi_pend_ff <= 1'b0;
      nmi_fill_ff <= 2'h0;
    end else begin
      nmi_s1_ff <= nxt_nmi_s1;
      nmi_s2_ff <= nxt_nmi_s2;
      nmi_prev_ff <= nxt_nmi_prev;
      nmi_pend_ff <= nxt_nmi_pend;
      nmi_fill_ff <= nxt_nmi_fill;
    end
  end

  // ----------------------------------------------------------------
  // Source vector, one bit per vector number 0..63
  // ----------------------------------------------------------------
  logic [63:0] req_vec;
  logic [63:0] lvl_vec;
  logic [7:0] pin_req;
  logic [14:0] tmr_req;
  logic [7:0] ser_req;

  always_comb begin
    pin_req = pin_flag & pin_request_enable_reg_i;
    // Requests steered to the DMA unit bypass the controller entirely.
    tmr_req = timer_unit_request_i & ~timer_dma_route_i;
    ser_req = serial_unit_request_i & ~serial_dma_route_i;
    // Reserved vector slots are never driven, so they can never win.
    req_vec = 64'h0;
    lvl_vec = 64'h0;

    for (int i = 0; i < 8; i++) begin
      req_vec[`ISV_VEC_PIN_BASE + i] = pin_req[i];
    end
    lvl_vec[`ISV_VEC_PIN_BASE + 0] = priority_reg_a_i[`ISV_PRA_PIN0];
    lvl_vec[`ISV_VEC_PIN_BASE + 1] = priority_reg_a_i[`ISV_PRA_PIN1];
    for (int i = 2; i < 4; i++) begin
      lvl_vec[`ISV_VEC_PIN_BASE + i] = priority_reg_a_i[`ISV_PRA_PIN23];
    end
    for (int i = 4; i < 8; i++) begin
      lvl_vec[`ISV_VEC_PIN_BASE + i] = priority_reg_a_i[`ISV_PRA_PIN47];
    end

    req_vec[`ISV_VEC_WDT] = watchdog_interval_request_i;
    req_vec[`ISV_VEC_RFSH] = refresh_compare_request_i;
    lvl_vec[`ISV_VEC_WDT] = priority_reg_a_i[`ISV_PRA_WDT];
    lvl_vec[`ISV_VEC_RFSH] = priority_reg_a_i[`ISV_PRA_WDT];

    // Timer request bit 3*channel+k feeds slot k of that channel's group.
    for (int i = 0; i < 3; i++) begin
      req_vec[`ISV_VEC_TMR0 + i] = tmr_req[i];
      req_vec[`ISV_VEC_TMR1 + i] = tmr_req[3 + i];
      req_vec[`ISV_VEC_TMR2 + i] = tmr_req[6 + i];
      req_vec[`ISV_VEC_TMR3 + i] = tmr_req[9 + i];
      req_vec[`ISV_VEC_TMR4 + i] = tmr_req[12 + i];
      lvl_vec[`ISV_VEC_TMR0 + i] = priority_reg_a_i[`ISV_PRA_TMR0];
      lvl_vec[`ISV_VEC_TMR1 + i] = priority_reg_a_i[`ISV_PRA_TMR1];
      lvl_vec[`ISV_VEC_TMR2 + i] = priority_reg_a_i[`ISV_PRA_TMR2];
      lvl_vec[`ISV_VEC_TMR3 + i] = priority_reg_b_i[`ISV_PRB_TMR3];
      lvl_vec[`ISV_VEC_TMR4 + i] = priority_reg_b_i[`ISV_PRB_TMR4];
    end

    // Serial bits run receive error, receive full, transmit empty, transmit end.
    for (int i = 0; i < 4; i++) begin
      req_vec[`ISV_VEC_DMA0 + i] = dma_transfer_end_request_i[i];
      req_vec[`ISV_VEC_DMA1 + i] = dma_transfer_end_request_i[4 + i];
      req_vec[`ISV_VEC_SER0 + i] = ser_req[i];
      req_vec[`ISV_VEC_SER1 + i] = ser_req[4 + i];
      lvl_vec[`ISV_VEC_DMA0 + i] = priority_reg_b_i[`ISV_PRB_DMA0];
      lvl_vec[`ISV_VEC_DMA1 + i] = priority_reg_b_i[`ISV_PRB_DMA1];
      lvl_vec[`ISV_VEC_SER0 + i] = priority_reg_b_i[`ISV_PRB_SER0];
      lvl_vec[`ISV_VEC_SER1 + i] = priority_reg_b_i[`ISV_PRB_SER1];
    end

    req_vec[`ISV_VEC_CONV] = conversion_end_request_i;
    lvl_vec[`ISV_VEC_CONV] = priority_reg_b_i[`ISV_PRB_CONV];
    // Bit 0 of priority register B is reserved; it is accepted and ignored.
  end

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  // A flat scan over all 64 slots is long logic, but at this clock rate it
  // settles in one cycle and keeps the answer a single registered stage.
  logic [63:0] hi_vec;
  logic win_valid;
  logic win_level;
  logic win_nmi;
  isv_pkg::isv_vec_t win_vec;
  isv_pkg::isv_src_t win_src;

  always_comb begin
    // Both priority registers reset to zero, which puts every source at level
    // 0 and leaves the default fixed order in force.
    hi_vec = req_vec & lvl_vec;
    win_valid = 1'b0;
    win_level = 1'b0;
    win_nmi = 1'b0;
    win_vec = '0;
    win_src = isv_pkg::ISV_SRC_NONE;
    // Scan downward so the smallest vector number is the last to win.
    for (int v = 63; v >= 0; v--) begin
      if (req_vec[v] && !win_level) begin
        win_valid = 1'b1;
        win_vec = 6'(v);
      end
    end

    for (int v = 63; v >= 0; v--) begin
      if (hi_vec[v]) begin
        win_level = 1'b1;
        win_vec = 6'(v);
      end
    end

    if (nmi_pend_ff) begin
      win_nmi = 1'b1;
      win_valid = 1'b1;
      win_level = 1'b1;
      win_vec = `ISV_VEC_NMI;
    end

    if (win_nmi) begin
      win_src = isv_pkg::ISV_SRC_NMI;
    end else if (win_valid && win_vec >= `ISV_VEC_PIN_BASE && win_vec < `ISV_VEC_WDT) begin
      win_src = isv_pkg::ISV_SRC_PIN;
    end else if (win_valid) begin
      win_src = isv_pkg::ISV_SRC_INT;
    end
  end

  // ----------------------------------------------------------------
  // Registered answer to the core
  // ----------------------------------------------------------------
  // The answer is registered so the core sees a winner that cannot glitch
  // while requests change underneath it. The price is one cycle of latency
  // between a request and its appearance at the core side.
  logic valid_ff;
  logic level_ff;
  logic wake_ff;
  isv_pkg::isv_vec_t vec_ff;
  isv_pkg::isv_addr_t addr_ff;
  isv_pkg::isv_src_t src_ff;
  logic nxt_wake;
  isv_pkg::isv_addr_t nxt_addr;

  always_comb begin
    nxt_addr = {10'h000, win_vec} << `ISV_VEC_ADDR_SHIFT;
    // Only NMI and the first three pins may wake from standby.
    // Wake follows the live pin level, so an edge-mode pin wakes only while held low.
    nxt_wake = nmi_pend_ff
             | (|(pin_low & pin_request_enable_reg_i & `ISV_WAKE_MASK));
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      valid_ff <= 1'b0;
      level_ff <= 1'b0;
      vec_ff <= '0;
      addr_ff <= '0;
      src_ff <= isv_pkg::ISV_SRC_NONE;
      wake_ff <= 1'b0;
    end else begin
      valid_ff <= win_valid;
      level_ff <= win_level;
      vec_ff <= win_vec;
      addr_ff <= nxt_addr;
      src_ff <= win_src;
      wake_ff <= nxt_wake;
    end
  end

  assign pin_request_flag_reg_o = pin_flag;
  assign nmi_pending_o = nmi_pend_ff;
  assign req_valid_o = valid_ff;
  assign req_level_o = level_ff;
  assign req_vector_o = vec_ff;
  assign req_vec_addr_o = addr_ff;
  assign req_source_o = src_ff;
  assign wake_o = wake_ff;
endmodule // isv_source_vectoring
`default_nettype wire

// File: rtl/isv_cfg.svh
`ifndef ISV_CFG_SVH
`define ISV_CFG_SVH
`define ISV_NUM_PINS 8
`define ISV_NUM_INT 34
`define ISV_VEC_W 6
`define ISV_VEC_NMI 6'h07
`define ISV_VEC_PIN_BASE 6'h0c
`define ISV_VEC_WDT 6'h14
`define ISV_VEC_RFSH 6'h15
`define ISV_VEC_TMR0 6'h18
`define ISV_VEC_TMR1 6'h1c
`define ISV_VEC_TMR2 6'h20
`define ISV_VEC_TMR3 6'h24
`define ISV_VEC_TMR4 6'h28
`define ISV_VEC_DMA0 6'h2c
`define ISV_VEC_DMA1 6'h30
`define ISV_VEC_SER0 6'h34
`define ISV_VEC_SER1 6'h38
`define ISV_VEC_CONV 6'h3c
`define ISV_VEC_ADDR_SHIFT 2
`define ISV_PRA_PIN0 7
`define ISV_PRA_PIN1 6
`define ISV_PRA_PIN23 5
`define ISV_PRA_PIN47 4
`define ISV_PRA_WDT 3
`define ISV_PRA_TMR0 2
`define ISV_PRA_TMR1 1
`define ISV_PRA_TMR2 0
`define ISV_PRB_TMR3 7
`define ISV_PRB_TMR4 6
`define ISV_PRB_DMA0 5
`define ISV_PRB_DMA1 4
`define ISV_PRB_SER0 3
`define ISV_PRB_SER1 2
`define ISV_PRB_CONV 1
`define ISV_REG_RESET 8'h00
`define ISV_WAKE_MASK 8'h07
`define ISV_SYNC_FILL 2'h3
`endif

// File: rtl/isv_pkg.sv
`default_nettype none
package isv_pkg;
  typedef logic [5:0] isv_vec_t;
  typedef logic [15:0] isv_addr_t;
  typedef enum logic [1:0] {
    ISV_SRC_NONE,
    ISV_SRC_NMI,
    ISV_SRC_PIN,
    ISV_SRC_INT
  } isv_src_t;
endpackage
`default_nettype wire

// File: rtl/isv_pin_detect.sv
`timescale 1ns/1ps
`default_nettype none
`include "isv_cfg.svh"
// One external request pin: synchroniser, sense logic and pending flag.
module isv_pin_detect (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Pin and control
  input wire logic pin_n_i,
  input wire logic sense_edge_i,
  input wire logic clear_i,
  // Status
  output logic flag_o,
  output logic asserted_o
);
  logic sync1_ff;
  logic sync2_ff;
  logic prev_ff;
  logic flag_ff;
  logic nxt_sync1;
  logic nxt_sync2;
  logic nxt_prev;
  logic nxt_flag;
  logic set_cond;

  always_comb begin
    nxt_sync1 = pin_n_i;
    nxt_sync2 = sync1_ff;
    nxt_prev = sync2_ff;
    // Level mode sets while low, edge mode on high-to-low.
    set_cond = sense_edge_i ? (prev_ff & ~sync2_ff) : ~sync2_ff;
    // A set in the clearing cycle wins so no request is lost.
    nxt_flag = set_cond | (flag_ff & ~clear_i);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
      prev_ff <= 1'b1;
      flag_ff <= 1'b0;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      prev_ff <= nxt_prev;
      flag_ff <= nxt_flag;
    end
  end

  assign flag_o = flag_ff;
  assign asserted_o = ~sync2_ff;
endmodule // isv_pin_detect
`default_nettype wire

// File: verif/isv_source_vectoring_sva.sv
`timescale 1ns/1ps
`default_nettype none
module isv_source_vectoring_sva (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Inputs
  input wire logic nmi_pin_i,
  input wire logic [7:0] irq_pin_n_i,
  input wire logic nmi_edge_select_i,
  input wire logic [7:0] pin_sense_select_reg_i,
  input wire logic [7:0] pin_request_enable_reg_i,
  input wire logic [7:0] pin_flag_clear_i,
  // Outputs
  input wire logic [7:0] pin_request_flag_reg_o,
  input wire logic nmi_pending_o,
  input wire logic req_valid_o,
  input wire isv_pkg::isv_vec_t req_vector_o,
  input wire isv_pkg::isv_addr_t req_vec_addr_o,
  input wire logic [1:0] req_source_o,
  input wire logic wake_o
);
  // Flags seen set with no clear pulse; each must still be set a cycle on.
  logic [7:0] kept_ff;
  logic [7:0] nxt_kept;
  always_comb nxt_kept = pin_request_flag_reg_o & ~pin_flag_clear_i;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) kept_ff <= 8'h00;
    else kept_ff <= nxt_kept;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_pin0_low;
    (!irq_pin_n_i[0] && !pin_sense_select_reg_i[0])[*3];
  endsequence
  sequence s_nmi_rise;
    (nmi_edge_select_i && !nmi_pin_i) ##1 (nmi_edge_select_i && nmi_pin_i)[*3];
  endsequence
  sequence s_quiet;
    (&(irq_pin_n_i[2:0] | ~pin_request_enable_reg_i[2:0]) && $stable(nmi_pin_i)
      && !nmi_pending_o)[*6];
  endsequence
  a_nmi_top: assert property (nmi_pending_o && $past(nmi_pending_o) |-> req_valid_o
    && req_source_o == isv_pkg::ISV_SRC_NMI && req_vector_o == 6'h07) else $error("nmi lost");
  a_vec_addr: assert property (req_valid_o |->
    req_vec_addr_o == {8'h00, req_vector_o, 2'b00}) else $error("bad address");
  a_pin_vec: assert property (req_valid_o && req_source_o == isv_pkg::ISV_SRC_PIN |->
    req_vector_o >= 6'h0c && req_vector_o <= 6'h13) else $error("bad pin vector");
  a_pin_level: assert property (s_pin0_low |-> ##2 pin_request_flag_reg_o[0])
    else $error("level flag missing");
  a_flag_hold: assert property ((kept_ff & ~pin_request_flag_reg_o) == 8'h00)
    else $error("flag dropped");
  a_nmi_edge: assert property (s_nmi_rise |-> ##[1:3] nmi_pending_o)
    else $error("nmi edge missed");
  a_wake_pin: assert property ((!irq_pin_n_i[0] && pin_request_enable_reg_i[0])[*3]
    |-> ##[0:2] wake_o) else $error("no wake");
  a_no_wake: assert property (s_quiet |-> !wake_o)
    else $error("stray wake");
endmodule // isv_source_vectoring_sva
bind isv_source_vectoring isv_source_vectoring_sva i_isv_source_vectoring_sva (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .nmi_pin_i(nmi_pin_i),
  .irq_pin_n_i(irq_pin_n_i), .nmi_edge_select_i(nmi_edge_select_i),
  .pin_sense_select_reg_i(pin_sense_select_reg_i),
  .pin_request_enable_reg_i(pin_request_enable_reg_i), .pin_flag_clear_i(pin_flag_clear_i),
  .pin_request_flag_reg_o(pin_request_flag_reg_o), .nmi_pending_o(nmi_pending_o),
  .req_valid_o(req_valid_o), .req_vector_o(req_vector_o), .req_vec_addr_o(req_vec_addr_o),
  .req_source_o(req_source_o), .wake_o(wake_o));
`default_nettype wire

// File: verif/isv_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// Core stand-in: takes the non-maskable request after a set delay.
module isv_core_model #(
  parameter int ACK_DELAY = 3
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Request and acknowledge
  input wire logic nmi_pending_i,
  output logic nmi_ack_o
);
  int wait_cnt;
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_cnt <= 0;
      nmi_ack_o <= 1'b0;
    end else if (nmi_pending_i && !nmi_ack_o && wait_cnt < ACK_DELAY) begin
      wait_cnt <= wait_cnt + 1;
    end else begin
      // No mask holds this request back, so it is always taken.
      nmi_ack_o <= nmi_pending_i && !nmi_ack_o;
      wait_cnt <= 0;
    end
  end
endmodule // isv_core_model
`default_nettype wire

// File: verif/isv_source_vectoring_test.sv
`timescale 1ns/1ps
`default_nettype none
module isv_source_vectoring_test;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic nmi_pin_i = 1'b0;
  logic nmi_sel = 1'b1;
  logic nmi_ack;
  logic [7:0] pins_n = 8'hff, sense = 8'h00, enable = 8'h00;
  logic [7:0] pra = 8'h00, prb = 8'h00, clr = 8'h00, flags, ser_route = 8'h00;
  logic [33:0] int_req = '0;
  logic [14:0] tmr_route = '0;
  logic nmi_pend, valid, level, wake;
  isv_pkg::isv_vec_t vec;
  isv_pkg::isv_addr_t addr;
  isv_pkg::isv_src_t src;
  int num_errors = 0, num_checks = 0, cycles = 0;
  always #25 ref_clk_i = ~ref_clk_i;
  isv_source_vectoring i_isv_source_vectoring (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .nmi_pin_i(nmi_pin_i), .irq_pin_n_i(pins_n), .nmi_edge_select_i(nmi_sel),
    .pin_sense_select_reg_i(sense), .pin_request_enable_reg_i(enable),
    .priority_reg_a_i(pra), .priority_reg_b_i(prb), .pin_flag_clear_i(clr),
    .watchdog_interval_request_i(int_req[0]), .refresh_compare_request_i(int_req[1]),
    .timer_unit_request_i(int_req[16:2]), .timer_dma_route_i(tmr_route),
    .dma_transfer_end_request_i(int_req[24:17]), .serial_unit_request_i(int_req[32:25]),
    .serial_dma_route_i(ser_route), .conversion_end_request_i(int_req[33]),
    .nmi_ack_i(nmi_ack), .pin_request_flag_reg_o(flags), .nmi_pending_o(nmi_pend),
    .req_valid_o(valid), .req_level_o(level), .req_vector_o(vec),
    .req_vec_addr_o(addr), .req_source_o(src), .wake_o(wake));
  isv_core_model i_isv_core_model (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .nmi_pending_i(nmi_pend), .nmi_ack_o(nmi_ack));
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic wait_nmi(input logic lvl);
    for (int n = 0; n < 12 && nmi_pend !== lvl; n++) wait_cyc(1);
    chk(nmi_pend, lvl);
  endtask
  task automatic idle();
    int_req = '0;
    pins_n = 8'hff;
    enable = 8'h00;
    pra = 8'h00;
    prb = 8'h00;
    wait_cyc(3);
    clr = 8'hff;
    wait_cyc(1);
    clr = 8'h00;
    wait_cyc(2);
  endtask
  function automatic logic [5:0] int_vec(input int i);
    if (i < 2) return 6'(20 + i);
    if (i < 17) return 6'(24 + 4 * ((i - 2) / 3) + (i - 2) % 3);
    if (i < 33) return 6'(27 + i);
    return 6'h3c;
  endfunction
  task automatic t_internal();
    for (int i = 0; i < 34; i++) begin
      int_req = 34'h1 << i;
      wait_cyc(3);
      chk({valid, src, vec}, {1'b1, isv_pkg::ISV_SRC_INT, int_vec(i)});
      chk(addr, {8'h00, int_vec(i), 2'b00});
      int_req = '0;
      wait_cyc(3);
      chk(valid, 1'b0);
    end
    $display("done internal");
  endtask
  task automatic t_pins();
    for (int k = 0; k < 8; k++) begin
      enable = 8'h01 << k;
      sense = {4{2'b10}};
      pins_n[k] = 1'b0;
      wait_cyc(6);
      chk(flags, 8'h01 << k);
      chk({src, vec}, {isv_pkg::ISV_SRC_PIN, 6'(12 + k)});
      chk(wake, k < 3);
      idle();
      chk({valid, flags}, 9'h000);
    end
    sense = 8'h00;
    pins_n[5] = 1'b0;
    wait_cyc(6);
    chk({valid, flags}, 9'h020);
    idle();
    $display("done pins");
  endtask
  task automatic t_priority();
    enable = 8'h80;
    pins_n[7] = 1'b0;
    int_req[0] = 1'b1;
    wait_cyc(6);
    chk({level, vec}, {1'b0, 6'h13});
    pra = 8'h08;
    wait_cyc(3);
    chk({level, vec}, {1'b1, 6'h14});
    pra = 8'h18;
    wait_cyc(3);
    chk({level, vec}, {1'b1, 6'h13});
    pra = 8'h00;
    prb = 8'h02;
    int_req[33] = 1'b1;
    wait_cyc(3);
    chk({level, vec, flags}, {1'b1, 6'h3c, 8'h80});
    idle();
    tmr_route = 15'h7fff;
    ser_route = 8'hff;
    int_req = {1'b0, 8'hff, 8'h00, 15'h7fff, 2'b00};
    wait_cyc(3);
    chk(valid, 1'b0);
    tmr_route = 15'h7ffe;
    wait_cyc(3);
    chk(vec, 6'h18);
    tmr_route = '0;
    ser_route = 8'h00;
    idle();
    $display("done priority");
  endtask
  task automatic t_nmi();
    enable = 8'h01;
    pra = 8'h80;
    pins_n[0] = 1'b0;
    nmi_pin_i = 1'b1;
    wait_nmi(1'b1);
    wait_cyc(1);
    chk({src, vec, addr[7:0]}, {isv_pkg::ISV_SRC_NMI, 6'h07, 8'h1c});
    wait_nmi(1'b0);
    wait_cyc(1);
    chk(vec, 6'h0c);
    nmi_pin_i = 1'b0;
    wait_cyc(8);
    chk(nmi_pend, 1'b0);
    nmi_sel = 1'b0;
    wait_cyc(2);
    nmi_pin_i = 1'b1;
    wait_cyc(8);
    chk(nmi_pend, 1'b0);
    nmi_pin_i = 1'b0;
    wait_nmi(1'b1);
    idle();
    $display("done nmi");
  endtask
  initial begin
    wait_cyc(2);
    rst_n_i = 1'b1;
    wait_cyc(1);
    chk({src, valid, nmi_pend, wake, flags}, 16'h0000);
    t_internal();
    t_pins();
    t_priority();
    t_nmi();
    test_done();
  end
endmodule // isv_source_vectoring_test
`default_nettype wire
